// file: logic/sfm_in_decode.sv
// Decoder from the input terminal to one safety request
`timescale 1ns/1ps
`default_nettype none

module sfm_in_decode
  import sfm_pkg::*;
(
  // Mapping carrier
  sfm_map_if.decode m
);

  // ****************************************************************
  // One request per input code
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SFM_NUM_REQ; gi++)
    begin : g_req
      // Open terminal raises the request of the assigned code
      assign m.req[gi] = m.pin_open && (m.in_sel == 4'(gi + 1));
    end
  endgenerate

endmodule : sfm_in_decode

`default_nettype wire

// file: logic/sfm_io_mapper.sv
// Top of the safety function I/O mapper
// Operation
// - Input terminal routes to the request picked by the input assignment.
// - Open input with torque-off assignment activates safe torque off.
// - Open input with stop-one assignment activates safe stop 1.
// - Open input with stop-two assignment activates safe stop 2 and operating stop.
// - Open input with speed-one assignment activates speed limit 1 with its settings.
// - Open input with positive-direction assignment monitors increasing direction.
// - Open input with negative-direction assignment monitors decreasing direction.
// - Open input with increment assignment activates limited increment.
// - Open input with torque-one assignment activates torque limit 1 with its bounds.
// - Network commands are accepted as an additional request source beside the terminal.
// - Output terminal carries the indication picked by the output assignment.
// - Network status is reported while the output terminal stays usable.
// - Speed monitor output closes when monitoring and speed at or below threshold.
// - Brake output drives brake control, open while operating.
// - Torque-off output opens while safe torque off is active.
// - Operating-stop output opens while stopped motor is monitored.
// - Stop-one output opens while safe stop 1 is active.
// - Stop-two output opens while safe stop 2 and operating stop is active.
// - Four speed-limit outputs, each open while its function is active.
// - Positive and negative direction outputs open while safe direction is active in their own direction.
// - Increment output opens while limited increment is active.
// - Four torque-limit outputs; only torque limit 1 opens while its function is active, the other three stay closed.
`timescale 1ns/1ps
`default_nettype none

module sfm_io_mapper
  import sfm_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // Safety terminals
  input  wire logic                   in_pin_open,
  output var  logic                   out_pin_closed,
  // Function status from the monitors
  input  wire logic [SFM_NUM_FN-1:0]  fn_active,
  // Requests towards the monitors
  output var  logic [SFM_NUM_REQ-1:0] safety_request,
  // Network status
  output var  logic [SFM_NUM_IND-1:0] net_indication,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output var  logic [31:0]            reg_rdata
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  logic [2:0] pin_sync_r;
  logic       pin_open_r;
  logic       pin_open_nxt;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pin_sync_r <= 3'h7;
    else
      pin_sync_r <= {pin_sync_r[1:0], in_pin_open};
  end

  // A change counts once the second and third stage agree; open at reset is safe
  assign pin_open_nxt = (pin_sync_r[1] == pin_sync_r[2]) ? pin_sync_r[2] : pin_open_r;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pin_open_r <= 1'b1;
    else
      pin_open_r <= pin_open_nxt;
  end

  // ****************************************************************
  // Function status sampling
  // ****************************************************************
  logic [SFM_NUM_FN-1:0] fn_r;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      fn_r <= '0;
    else
      fn_r <= fn_active;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  sfm_in_sel_t            in_sel_r;
  sfm_out_sel_t           out_sel_r;
  logic                   net_src_r;
  logic [SFM_NUM_REQ-1:0] net_cmd_r;

  wire wr_in   = reg_wr && (reg_addr == SFM_ADDR_IN_ASSIGN);
  wire wr_out  = reg_wr && (reg_addr == SFM_ADDR_OUT_ASSIGN);
  wire wr_src  = reg_wr && (reg_addr == SFM_ADDR_SOURCE);
  wire wr_net  = reg_wr && (reg_addr == SFM_ADDR_NET_CMD);
  wire in_ok   = reg_wdata[3:0] <= 4'(SFM_NUM_REQ);
  wire out_ok  = reg_wdata[4:0] <= SFM_OUT_CODE_MAX;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      in_sel_r  <= sfm_in_sel_t'(SFM_IN_RST);
      out_sel_r <= sfm_out_sel_t'(SFM_OUT_RST);
      net_src_r <= 1'b0;
      net_cmd_r <= SFM_NET_RST;
    end
    else
    begin
      if (wr_in && in_ok)
        in_sel_r <= sfm_in_sel_t'(reg_wdata[3:0]);
      if (wr_out && out_ok)
        out_sel_r <= sfm_out_sel_t'(reg_wdata[4:0]);
      if (wr_src)
        net_src_r <= reg_wdata[0];
      if (wr_net)
        net_cmd_r <= reg_wdata[SFM_NUM_REQ-1:0];
    end
  end

  // ****************************************************************
  // Mapping
  // ****************************************************************
  sfm_map_if m ();

  assign m.in_sel   = in_sel_r;
  assign m.out_sel  = out_sel_r;
  assign m.pin_open = pin_open_r;
  assign m.fn       = fn_r;

  sfm_in_decode u_dec
  (
    .m (m)
  );

  sfm_out_encode u_enc
  (
    .m (m)
  );

  // Network requests act beside the terminal
  wire [SFM_NUM_REQ-1:0] req_nxt = m.req | (net_src_r ? net_cmd_r : '0);

  // Named requests
  wire torque_off_request         = req_nxt[SFM_RQ_TORQUE_OFF];
  wire stop_one_request           = req_nxt[SFM_RQ_STOP_ONE];
  wire stop_two_request           = req_nxt[SFM_RQ_STOP_TWO];
  wire speed_limit_one_request    = req_nxt[SFM_RQ_SPEED_ONE];
  wire positive_direction_request = req_nxt[SFM_RQ_POS_DIR];
  wire negative_direction_request = req_nxt[SFM_RQ_NEG_DIR];
  wire increment_limit_request    = req_nxt[SFM_RQ_INCREMENT];
  wire torque_limit_one_request   = req_nxt[SFM_RQ_TORQUE_ONE];

  wire [SFM_NUM_REQ-1:0] req_vec = {torque_limit_one_request, increment_limit_request,
                                    negative_direction_request, positive_direction_request,
                                    speed_limit_one_request, stop_two_request,
                                    stop_one_request, torque_off_request};

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      safety_request <= '0;
      out_pin_closed <= 1'b0;
      net_indication <= '0;
    end
    else
    begin
      safety_request <= req_vec;
      out_pin_closed <= m.out_closed;
      net_indication <= m.ind;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  logic [31:0] rdata_nxt;

  always_comb
  begin
    unique case (reg_addr)
      SFM_ADDR_IN_ASSIGN:  rdata_nxt = 32'(in_sel_r);
      SFM_ADDR_OUT_ASSIGN: rdata_nxt = 32'(out_sel_r);
      SFM_ADDR_SOURCE:     rdata_nxt = 32'(net_src_r);
      SFM_ADDR_NET_CMD:    rdata_nxt = 32'(net_cmd_r);
      SFM_ADDR_REQ_STAT:   rdata_nxt = 32'(safety_request);
      SFM_ADDR_IND_STAT:   rdata_nxt = 32'(net_indication);
      SFM_ADDR_FN_STAT:    rdata_nxt = 32'(fn_r);
      SFM_ADDR_PIN_STAT:   rdata_nxt = 32'({out_pin_closed, pin_open_r});
      default:             rdata_nxt = SFM_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= SFM_UNMAPPED;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= SFM_UNMAPPED;
  end

endmodule : sfm_io_mapper

`default_nettype wire

// file: logic/sfm_map_if.sv
// Interface carrying requests and indications between mapper modules
`timescale 1ns/1ps
`default_nettype none

interface sfm_map_if;
  import sfm_pkg::*;
  logic [SFM_NUM_REQ-1:0] req;
  logic [SFM_NUM_IND-1:0] ind;
  logic [SFM_NUM_FN-1:0]  fn;
  sfm_in_sel_t            in_sel;
  sfm_out_sel_t           out_sel;
  logic                   pin_open;
  logic                   out_closed;

  modport decode
  (
    input  in_sel,
    input  pin_open,
    output req
  );
  modport encode
  (
    input  fn,
    input  out_sel,
    output ind,
    output out_closed
  );
  modport top
  (
    output in_sel,
    output out_sel,
    output pin_open,
    output fn,
    input  req,
    input  ind,
    input  out_closed
  );
endinterface : sfm_map_if

`default_nettype wire

// file: logic/sfm_out_encode.sv
// Encoder from function status to the output terminal
`timescale 1ns/1ps
`default_nettype none

module sfm_out_encode
  import sfm_pkg::*;
(
  // Mapping carrier
  sfm_map_if.encode m
);

  // ****************************************************************
  // Indications, high means the function is active
  // ****************************************************************
  assign m.ind[0] = m.fn[SFM_FN_SPEED_MON] && m.fn[SFM_FN_SPEED_LOW];
  assign m.ind[1] = m.fn[SFM_FN_BRAKE];
  assign m.ind[2] = m.fn[SFM_FN_TORQUE_OFF];
  assign m.ind[3] = m.fn[SFM_FN_OP_STOP];
  assign m.ind[4] = m.fn[SFM_FN_STOP_ONE];
  assign m.ind[5] = m.fn[SFM_FN_STOP_TWO];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lim
      assign m.ind[6 + gi]  = m.fn[SFM_FN_SPEED_BASE + gi];
      assign m.ind[13 + gi] = (gi == 0) ? m.fn[SFM_FN_TORQUE_ONE] : 1'b0;
    end
  endgenerate

  assign m.ind[10] = m.fn[SFM_FN_DIR_ANY] && m.fn[SFM_FN_POS_DIR];
  assign m.ind[11] = m.fn[SFM_FN_DIR_ANY] && m.fn[SFM_FN_NEG_DIR];
  assign m.ind[12] = m.fn[SFM_FN_INCREMENT];

  // ****************************************************************
  // Terminal contact: speed monitor closes when true, others open
  // ****************************************************************
  wire sel_valid = (m.out_sel != SFM_OUT_NONE);
  wire sel_ind   = m.ind[m.out_sel - 5'h01];
  wire is_speed  = (m.out_sel == SFM_OUT_SPEED_MON);

  assign m.out_closed = sel_valid && (is_speed ? sel_ind : !sel_ind);

endmodule : sfm_out_encode

`default_nettype wire

// file: logic/sfm_pkg.sv
// Package of constants and types for the safety function I/O mapper
package sfm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] SFM_ADDR_IN_ASSIGN  = 4'h0;
  localparam logic [3:0] SFM_ADDR_OUT_ASSIGN = 4'h1;
  localparam logic [3:0] SFM_ADDR_SOURCE     = 4'h2;
  localparam logic [3:0] SFM_ADDR_NET_CMD    = 4'h3;
  localparam logic [3:0] SFM_ADDR_REQ_STAT   = 4'h4;
  localparam logic [3:0] SFM_ADDR_IND_STAT   = 4'h5;
  localparam logic [3:0] SFM_ADDR_FN_STAT    = 4'h6;
  localparam logic [3:0] SFM_ADDR_PIN_STAT   = 4'h7;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int          SFM_NUM_REQ      = 8;
  localparam int          SFM_NUM_IND      = 17;
  localparam int          SFM_NUM_FN       = 16;
  localparam logic [3:0]  SFM_IN_RST       = 4'h1;
  localparam logic [4:0]  SFM_OUT_RST      = 5'h02;
  localparam logic [7:0]  SFM_NET_RST      = 8'h00;
  localparam logic [31:0] SFM_UNMAPPED     = 32'h0000_0000;

  // ****************************************************************
  // Input assignment codes
  // ****************************************************************
  typedef enum logic [3:0] {
    SFM_IN_NONE        = 4'b0000,
    SFM_IN_TORQUE_OFF  = 4'b0001,
    SFM_IN_STOP_ONE    = 4'b0010,
    SFM_IN_STOP_TWO    = 4'b0011,
    SFM_IN_SPEED_ONE   = 4'b0100,
    SFM_IN_POS_DIR     = 4'b0101,
    SFM_IN_NEG_DIR     = 4'b0110,
    SFM_IN_INCREMENT   = 4'b0111,
    SFM_IN_TORQUE_ONE  = 4'b1000
  } sfm_in_sel_t;

  // Request bit positions, in the order of the input codes minus one
  localparam int SFM_RQ_TORQUE_OFF = 0;
  localparam int SFM_RQ_STOP_ONE   = 1;
  localparam int SFM_RQ_STOP_TWO   = 2;
  localparam int SFM_RQ_SPEED_ONE  = 3;
  localparam int SFM_RQ_POS_DIR    = 4;
  localparam int SFM_RQ_NEG_DIR    = 5;
  localparam int SFM_RQ_INCREMENT  = 6;
  localparam int SFM_RQ_TORQUE_ONE = 7;

  // Active function bit positions
  localparam int SFM_FN_TORQUE_OFF = 0;
  localparam int SFM_FN_STOP_ONE   = 1;
  localparam int SFM_FN_STOP_TWO   = 2;
  localparam int SFM_FN_OP_STOP    = 3;
  localparam int SFM_FN_SPEED_MON  = 4;
  localparam int SFM_FN_SPEED_LOW  = 5;
  localparam int SFM_FN_BRAKE      = 6;
  localparam int SFM_FN_SPEED_BASE = 7;
  localparam int SFM_FN_POS_DIR    = 11;
  localparam int SFM_FN_NEG_DIR    = 12;
  localparam int SFM_FN_INCREMENT  = 13;
  localparam int SFM_FN_TORQUE_ONE = 14;
  localparam int SFM_FN_DIR_ANY    = 15;

  // ****************************************************************
  // Output assignment codes
  // ****************************************************************
  typedef enum logic [4:0] {
    SFM_OUT_NONE        = 5'b00000,
    SFM_OUT_SPEED_MON   = 5'b00001,
    SFM_OUT_BRAKE       = 5'b00010,
    SFM_OUT_TORQUE_OFF  = 5'b00011,
    SFM_OUT_OP_STOP     = 5'b00100,
    SFM_OUT_STOP_ONE    = 5'b00101,
    SFM_OUT_STOP_TWO    = 5'b00110,
    SFM_OUT_SPEED_ONE   = 5'b00111,
    SFM_OUT_SPEED_TWO   = 5'b01000,
    SFM_OUT_SPEED_THREE = 5'b01001,
    SFM_OUT_SPEED_FOUR  = 5'b01010,
    SFM_OUT_POS_DIR     = 5'b01011,
    SFM_OUT_NEG_DIR     = 5'b01100,
    SFM_OUT_INCREMENT   = 5'b01101,
    SFM_OUT_TORQUE_ONE  = 5'b01110,
    SFM_OUT_TORQUE_TWO  = 5'b01111,
    SFM_OUT_TORQUE_THR  = 5'b10000,
    SFM_OUT_TORQUE_FOUR = 5'b10001
  } sfm_out_sel_t;

  // Indication bit positions, code minus one
  localparam logic [4:0] SFM_OUT_CODE_MAX = 5'h11;

endpackage : sfm_pkg

// file: verification/sfm_io_mapper_bench.sv
// Self-checking bench for the safety function I/O mapper
`timescale 1ns/1ps
`default_nettype none

module sfm_io_mapper_bench
  import sfm_pkg::*;
;
  logic        ref_clk   = 1'b0;
  logic        rstn      = 1'b0;
  logic        open_req  = 1'b0;
  logic [1:0]  lag       = 2'h0;
  logic [15:0] fn_active = 16'h0000;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  wire logic   in_pin_open;
  logic        out_pin_closed;
  logic [7:0]  safety_request;
  logic [16:0] net_indication;
  logic [31:0] reg_rdata;
  logic [31:0] exp_v;
  logic [15:0] fn_mask [18];
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          k;

  always #5 ref_clk = ~ref_clk;

  sfm_safety_ctrl ctrl_u (.ref_clk(ref_clk), .open_req(open_req), .lag(lag),
    .in_pin_open(in_pin_open));
  sfm_io_mapper dut_u (.ref_clk(ref_clk), .rstn(rstn), .in_pin_open(in_pin_open),
    .out_pin_closed(out_pin_closed), .fn_active(fn_active), .safety_request(safety_request),
    .net_indication(net_indication), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      $display("MISMATCH at %0t: run too long", $time);
      wrap_up;
    end
  end

  initial
  begin
    fn_mask = '{16'hFFFF, 16'h0030, 16'h0040, 16'h0001, 16'h0008, 16'h0002, 16'h0004,
                16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h9800, 16'h9800, 16'h2000,
                16'h4000, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    tick(8);
    rd(SFM_ADDR_IN_ASSIGN, 32'h0000_0001);
    rd(SFM_ADDR_OUT_ASSIGN, 32'h0000_0002);
    rd(4'h8, 32'h0000_0000);
    chk({31'h0000_0000, out_pin_closed}, 32'h0000_0001);
    // Every input assignment, open then closed, with prompt and slow controller
    for (k = 0; k <= 8; k++)
    begin
      wr(SFM_ADDR_IN_ASSIGN, 32'(k));
      exp_v = (k == 0) ? 32'h0000_0000 : 32'h0000_0001 << (k - 1);
      lag      <= 2'(k % 4);
      open_req <= 1'b1;
      tick(12);
      chk(32'(safety_request), exp_v);
      rd(SFM_ADDR_REQ_STAT, exp_v);
      @(posedge ref_clk) open_req <= 1'b0;
      tick(12);
      chk(32'(safety_request), 32'h0000_0000);
    end
    wr(SFM_ADDR_IN_ASSIGN, 32'h0000_0009);
    rd(SFM_ADDR_IN_ASSIGN, 32'h0000_0008);
    // Network commands beside the terminal
    wr(SFM_ADDR_SOURCE, 32'h0000_0001);
    wr(SFM_ADDR_NET_CMD, 32'h0000_0081);
    tick(3);
    chk(32'(safety_request), 32'h0000_0081);
    rd(SFM_ADDR_NET_CMD, 32'h0000_0081);
    rd(SFM_ADDR_SOURCE, 32'h0000_0001);
    wr(SFM_ADDR_NET_CMD, 32'h0000_0000);
    wr(SFM_ADDR_SOURCE, 32'h0000_0000);
    // Every output assignment, function idle then active
    for (k = 0; k <= 17; k++)
    begin
      wr(SFM_ADDR_OUT_ASSIGN, 32'(k));
      @(posedge ref_clk) fn_active <= 16'h0000;
      tick(4);
      chk({31'h0000_0000, out_pin_closed}, 32'(k > 1));
      chk(32'(net_indication), 32'h0000_0000);
      @(posedge ref_clk) fn_active <= fn_mask[k];
      tick(4);
      chk({31'h0000_0000, out_pin_closed}, 32'(k == 1 || k > 14));
      chk(32'(net_indication[(k + 16) % 17]), 32'(k > 0 && k < 15));
    end
    rd(SFM_ADDR_OUT_ASSIGN, 32'h0000_0011);
    wr(SFM_ADDR_OUT_ASSIGN, 32'h0000_0012);
    rd(SFM_ADDR_OUT_ASSIGN, 32'h0000_0011);
    rd(SFM_ADDR_IND_STAT, 32'h0000_3FFF);
    rd(SFM_ADDR_FN_STAT, 32'h0000_FFFF);
    rd(SFM_ADDR_PIN_STAT, 32'h0000_0002);
    wrap_up;
  end
endmodule : sfm_io_mapper_bench

`default_nettype wire

// file: verification/sfm_io_mapper_properties.sv
// Port checks for the safety function I/O mapper
`timescale 1ns/1ps
`default_nettype none

module sfm_io_mapper_checker
  import sfm_pkg::*;
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  // Terminal and status
  input wire logic                   out_pin_closed,
  input wire logic [SFM_NUM_FN-1:0]  fn_active,
  input wire logic [SFM_NUM_REQ-1:0] safety_request,
  input wire logic [SFM_NUM_IND-1:0] net_indication,
  // Register port
  input wire logic [3:0]             reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata
);
  // ********
  // Shadow of the settings
  // ********
  logic [3:0] in_sel_r;
  logic [4:0] out_sel_r;
  logic       src_r;
  logic [7:0] cmd_r;
  logic [1:0] age_r;
  wire        wr_in  = reg_wr && reg_addr == SFM_ADDR_IN_ASSIGN && reg_wdata[3:0] <= 4'h8;
  wire        wr_out = reg_wr && reg_addr == SFM_ADDR_OUT_ASSIGN
                       && reg_wdata[4:0] <= SFM_OUT_CODE_MAX;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      in_sel_r  <= SFM_IN_RST;
      out_sel_r <= SFM_OUT_RST;
      src_r     <= 1'b0;
      cmd_r     <= SFM_NET_RST;
      age_r     <= 2'h0;
    end
    else
    begin
      in_sel_r  <= wr_in ? reg_wdata[3:0] : in_sel_r;
      out_sel_r <= wr_out ? reg_wdata[4:0] : out_sel_r;
      src_r     <= (reg_wr && reg_addr == SFM_ADDR_SOURCE) ? reg_wdata[0] : src_r;
      cmd_r     <= (reg_wr && reg_addr == SFM_ADDR_NET_CMD) ? reg_wdata[7:0] : cmd_r;
      age_r     <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
    end
  end

  // ********
  // Assertions
  // ********
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence out_settled(logic [4:0] c);
    age_r == 2'h3 && out_sel_r == c && $past(out_sel_r) == c && $past(out_sel_r, 2) == c;
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not idle");
  rdata_req_a: assert property ($past(reg_rd) && $past(reg_addr) == SFM_ADDR_REQ_STAT
    && $stable(safety_request) |-> reg_rdata == {24'h00_0000, safety_request})
    else $error("request read wrong");
  req_single_a: assert property (!src_r && !$past(src_r, 2) |-> $onehot0(safety_request))
    else $error("terminal drives several requests");
  net_req_a: assert property (src_r && $past(src_r, 2) && $past(cmd_r) == cmd_r
    && $past(cmd_r, 2) == cmd_r |-> (safety_request & cmd_r) == cmd_r)
    else $error("network request missing");
  out_none_a: assert property (out_settled(5'h00) |-> !out_pin_closed)
    else $error("unassigned output closed");
  speed_mon_a: assert property (out_settled(5'h01) |->
    out_pin_closed == (($past(fn_active, 2) & 16'h0030) == 16'h0030))
    else $error("speed monitor output wrong");
  brake_out_a: assert property (out_settled(5'h02) |->
    out_pin_closed == (($past(fn_active, 2) & 16'h0040) == 16'h0000))
    else $error("brake output wrong");
  torque_off_a: assert property (out_settled(5'h03) |->
    out_pin_closed == (($past(fn_active, 2) & 16'h0001) == 16'h0000))
    else $error("torque off output wrong");
  tail_zero_a: assert property (net_indication[16:14] == 3'h0)
    else $error("unmonitored torque indication set");
  net_speed_a: assert property (age_r == 2'h3 |->
    net_indication[0] == (($past(fn_active, 2) & 16'h0030) == 16'h0030))
    else $error("network speed indication wrong");

  cover property (out_settled(5'h01) ##0 out_pin_closed);
  cover property (src_r && safety_request != 8'h00);
  cover property ($past(reg_rd) && reg_rdata != 32'h0000_0000);
endmodule : sfm_io_mapper_checker

bind sfm_io_mapper sfm_io_mapper_checker chk_u
(
  .ref_clk(ref_clk), .rstn(rstn), .out_pin_closed(out_pin_closed), .fn_active(fn_active),
  .safety_request(safety_request), .net_indication(net_indication), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

`default_nettype wire

// file: verification/sfm_safety_ctrl.sv
// Behavioural external safety controller on the input terminal
`timescale 1ns/1ps
`default_nettype none

module sfm_safety_ctrl
(
  // Clock
  input  wire logic       ref_clk,
  // Bench control
  input  wire logic       open_req,
  input  wire logic [1:0] lag,
  // Input terminal
  output var  logic       in_pin_open
);
  logic [3:0] dly_r;

  // Terminal closed except while a function is requested
  always_ff @(posedge ref_clk)
  begin
    dly_r <= {dly_r[2:0], open_req};
  end
  assign in_pin_open = (lag == 2'h0) ? open_req : dly_r[lag - 2'h1];
endmodule : sfm_safety_ctrl

`default_nettype wire
